// ==== common/dsc_map.svh ====
// register map, field positions and reset values of the converter strobe block
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// register indices; byte address is four times the index
`define DSC_IDX_CH_FIRST 6'h00
`define DSC_IDX_CH_LAST 6'h0e
`define DSC_IDX_SYNC_EN 6'h12
`define DSC_IDX_RANGE_SEL 6'h14
`define DSC_IDX_CAL 6'h1e
`define DSC_IDX_SYNC_STROBE 6'h20
`define DSC_IDX_RESET_ALL 6'h22
`define DSC_IDX_CAL_RESET 6'h24
`define DSC_IDX_TYPE_CHANGE 6'h26
`define DSC_IDX_REF_SEL 6'h28

// field positions
`define DSC_CAL_MSB 7
`define DSC_REF_MSB 1
`define DSC_SYNC_EN_BIT 0
`define DSC_RSEL_CH_LSB 0
`define DSC_RSEL_CH_MSB 2
`define DSC_RSEL_RANGE_LSB 3
`define DSC_RSEL_RANGE_MSB 4

// sizes and reset values
`define DSC_CH_COUNT 8
`define DSC_OUT_RESET_VALUE 16'h0000
`define DSC_CAL_RESET_VALUE 8'h00
`define DSC_RANGE_RESET_VALUE 2'b00
`define DSC_RSEL_RESET_VALUE 5'h00
`define DSC_REF_RESET_BIT1 1'b0
`define DSC_REF_RESET_BIT0 1'b0

// axi responses
`define DSC_RESP_OKAY 2'b00
`define DSC_RESP_SLVERR 2'b10

`endif

// ==== common/dsc_pkg.sv ====
// types of the converter strobe and calibration register block
package dsc_pkg;

  typedef enum logic [1:0] {
    DSC_REF_NEG10 = 2'b00,
    DSC_REF_ZERO = 2'b01,
    DSC_REF_POS10 = 2'b11
  } dsc_ref_t;

  typedef logic [1:0] dsc_range_t;
  typedef logic [15:0] dsc_word_t;

endpackage

// ==== logic/dsc_channel.sv ====
// one analog output channel: pending word and driven level
`include "dsc_map.svh"

module dsc_channel
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [1:0] lane_en,
  input wire logic [15:0] load_data,
  input wire logic sync_mode,
  input wire logic update,
  input wire logic clear,
  output dsc_word_t pending,
  output dsc_word_t level
);

  dsc_word_t merged;

  always_comb begin
    merged = pending;
    if (lane_en[0]) begin
      merged[7:0] = load_data[7:0];
    end
    if (lane_en[1]) begin
      merged[15:8] = load_data[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= `DSC_OUT_RESET_VALUE;
    end else if (clear) begin
      pending <= `DSC_OUT_RESET_VALUE;
    end else if (load) begin
      pending <= merged;
    end
  end

  // clear wins over a load in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= `DSC_OUT_RESET_VALUE;
    end else if (clear) begin
      level <= `DSC_OUT_RESET_VALUE;
    end else if (load && !sync_mode) begin
      level <= merged;
    end else if (update) begin
      level <= pending;
    end
  end

endmodule // dsc_channel

// ==== logic/dsc_regs.sv ====
// axi4-lite register block: calibration port, reference select and output strobes
//
// Functional notes
// - calibration write keeps bits 7..0 only
// - calibration read gives result, upper byte zero
// - sync strobe updates all channels together
// - without sync mode data drives output immediately
// - reset strobe resets every output channel
// - strobe resets the calibration controller
// - type strobe applies selected range to channel
// - reference index in bits 1..0, 10 unassigned
//
// Decided for this implementation: the AXI4-Lite register port.
`include "dsc_map.svh"

module dsc_regs
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] cal_result,
  output logic [127:0] dac_out,
  output logic [15:0] dac_range,
  output logic sync_mode,
  output logic [7:0] cal_value,
  output logic cal_value_pulse,
  output logic cal_ctrl_reset_pulse,
  output logic outputs_reset_pulse,
  output logic sync_update_pulse,
  output logic range_apply_pulse,
  output logic ref_index_bit1,
  output logic ref_index_bit0
);

  // write channel holding registers
  logic aw_held;
  logic w_held;
  logic [7:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic do_write;
  logic [5:0] widx;
  logic wr_mapped;
  logic wr_is_ch;
  logic [2:0] wr_ch;

  // internal one-cycle strobes
  logic hit_cal;
  logic hit_sync;
  logic hit_reset_all;
  logic hit_cal_reset;
  logic hit_type_change;
  logic hit_ref;
  logic hit_sync_en;
  logic hit_range_sel;
  logic ref_code_legal;

  logic [4:0] range_sel;
  dsc_word_t ch_pending [`DSC_CH_COUNT];
  dsc_word_t ch_level [`DSC_CH_COUNT];

  // read side
  logic [5:0] ridx;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  function automatic logic idx_is_ch(input logic [5:0] idx);
    idx_is_ch = (idx <= `DSC_IDX_CH_LAST) && !idx[0];
  endfunction

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = idx_is_ch(idx) ||
                 (idx == `DSC_IDX_SYNC_EN) ||
                 (idx == `DSC_IDX_RANGE_SEL) ||
                 (idx == `DSC_IDX_CAL) ||
                 (idx == `DSC_IDX_SYNC_STROBE) ||
                 (idx == `DSC_IDX_RESET_ALL) ||
                 (idx == `DSC_IDX_CAL_RESET) ||
                 (idx == `DSC_IDX_TYPE_CHANGE) ||
                 (idx == `DSC_IDX_REF_SEL);
  endfunction

  // ---------------- write address / data capture ----------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // only the low half-word carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'b00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wdata_q <= s_axi_wdata[15:0];
      wstrb_q <= s_axi_wstrb[1:0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign widx = awaddr_q[7:2];
  assign wr_mapped = idx_mapped(widx);
  assign wr_is_ch = idx_is_ch(widx);
  assign wr_ch = widx[3:1];

  // strobe decode ignores data and byte enables: any write counts
  always_comb begin
    hit_cal = 1'b0;
    hit_sync = 1'b0;
    hit_reset_all = 1'b0;
    hit_cal_reset = 1'b0;
    hit_type_change = 1'b0;
    hit_ref = 1'b0;
    hit_sync_en = 1'b0;
    hit_range_sel = 1'b0;
    if (do_write) begin
      case (widx)
        `DSC_IDX_CAL: hit_cal = 1'b1;
        `DSC_IDX_SYNC_STROBE: hit_sync = 1'b1;
        `DSC_IDX_RESET_ALL: hit_reset_all = 1'b1;
        `DSC_IDX_CAL_RESET: hit_cal_reset = 1'b1;
        `DSC_IDX_TYPE_CHANGE: hit_type_change = 1'b1;
        `DSC_IDX_REF_SEL: hit_ref = 1'b1;
        `DSC_IDX_SYNC_EN: hit_sync_en = 1'b1;
        `DSC_IDX_RANGE_SEL: hit_range_sel = 1'b1;
        // channel data and unmapped indices raise no strobe
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped index answers with an error and changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `DSC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= wr_mapped ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
    end
  end

  // ---------------- stored control ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_mode <= 1'b0;
    end else if (hit_sync_en && wstrb_q[0]) begin
      sync_mode <= wdata_q[`DSC_SYNC_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_sel <= `DSC_RSEL_RESET_VALUE;
    end else if (hit_range_sel && wstrb_q[0]) begin
      range_sel <= wdata_q[`DSC_RSEL_RANGE_MSB:`DSC_RSEL_CH_LSB];
    end
  end

  // upper byte is discarded on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_value <= `DSC_CAL_RESET_VALUE;
    end else if (hit_cal && wstrb_q[0]) begin
      cal_value <= wdata_q[`DSC_CAL_MSB:0];
    end
  end

  // unassigned code is dropped so the reference never floats
  assign ref_code_legal = wdata_q[`DSC_REF_MSB:0] inside {DSC_REF_NEG10, DSC_REF_ZERO, DSC_REF_POS10};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_index_bit1 <= `DSC_REF_RESET_BIT1;
      ref_index_bit0 <= `DSC_REF_RESET_BIT0;
    end else if (hit_ref && wstrb_q[0] && ref_code_legal) begin
      ref_index_bit1 <= wdata_q[1];
      ref_index_bit0 <= wdata_q[0];
    end
  end

  // range takes effect only on the type strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_range <= {`DSC_CH_COUNT{`DSC_RANGE_RESET_VALUE}};
    end else if (hit_type_change) begin
      for (int i = 0; i < `DSC_CH_COUNT; i++) begin
        if (range_sel[`DSC_RSEL_CH_MSB:`DSC_RSEL_CH_LSB] == 3'(i)) begin
          dac_range[2*i +: 2] <= range_sel[`DSC_RSEL_RANGE_MSB:`DSC_RSEL_RANGE_LSB];
        end
      end
    end
  end

  // registered copies of the strobes for the outside controllers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_value_pulse <= 1'b0;
    end else begin
      cal_value_pulse <= hit_cal;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_ctrl_reset_pulse <= 1'b0;
    end else begin
      cal_ctrl_reset_pulse <= hit_cal_reset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outputs_reset_pulse <= 1'b0;
    end else begin
      outputs_reset_pulse <= hit_reset_all;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_update_pulse <= 1'b0;
    end else begin
      sync_update_pulse <= hit_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_apply_pulse <= 1'b0;
    end else begin
      range_apply_pulse <= hit_type_change;
    end
  end

  // ---------------- output channels ----------------
  for (genvar g = 0; g < `DSC_CH_COUNT; g++) begin : g_ch
    dsc_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(do_write && wr_is_ch && (wr_ch == 3'(g))),
      .lane_en(wstrb_q),
      .load_data(wdata_q),
      .sync_mode(sync_mode),
      .update(hit_sync),
      .clear(hit_reset_all),
      .pending(ch_pending[g]),
      .level(ch_level[g])
    );
    assign dac_out[16*g +: 16] = ch_level[g];
  end

  // ---------------- read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ridx = s_axi_araddr[7:2];

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `DSC_RESP_OKAY;
    if (idx_is_ch(ridx)) begin
      next_rdata[15:0] = ch_pending[ridx[3:1]];
    end else begin
      case (ridx)
        `DSC_IDX_CAL: begin
          next_rdata[`DSC_CAL_MSB:0] = cal_result;
        end
        `DSC_IDX_SYNC_EN: begin
          next_rdata[`DSC_SYNC_EN_BIT] = sync_mode;
        end
        `DSC_IDX_RANGE_SEL: begin
          next_rdata[`DSC_RSEL_RANGE_MSB:`DSC_RSEL_CH_LSB] = range_sel;
        end
        // strobes and the reference select keep nothing readable
        `DSC_IDX_SYNC_STROBE, `DSC_IDX_RESET_ALL, `DSC_IDX_CAL_RESET, `DSC_IDX_TYPE_CHANGE, `DSC_IDX_REF_SEL: begin
          next_rdata = 32'h0000_0000;
        end
        default: begin
          next_rresp = `DSC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read data held until the next address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule // dsc_regs

// ==== bench/dsc_regs_asserts.sv ====
// checker of strobe pulses, output updates and read data of the register block
module dsc_regs_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [127:0] dac_out,
  input wire logic sync_mode,
  input wire logic [7:0] cal_value,
  input wire logic cal_value_pulse,
  input wire logic cal_ctrl_reset_pulse,
  input wire logic outputs_reset_pulse,
  input wire logic sync_update_pulse,
  input wire logic range_apply_pulse,
  input wire logic ref_index_bit1,
  input wire logic ref_index_bit0
);
  logic any_pulse;
  assign any_pulse = cal_value_pulse | cal_ctrl_reset_pulse | outputs_reset_pulse |
    sync_update_pulse | range_apply_pulse;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cal_only_written: assert property ($changed(cal_value) |-> cal_value_pulse)
    else $error("calibration value moved without a write");
  a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_sync_with_resp: assert property (sync_update_pulse |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'b00)
    else $error("sync pulse not tied to its write response");
  a_sync_holds_out: assert property (
    $changed(dac_out) && $past(sync_mode) |-> sync_update_pulse || outputs_reset_pulse)
    else $error("output moved in sync mode without strobe");
  a_reset_clears: assert property (outputs_reset_pulse |-> dac_out == 128'h0)
    else $error("outputs not cleared by reset strobe");
  a_cal_reset_resp: assert property (cal_ctrl_reset_pulse |-> $rose(s_axi_bvalid))
    else $error("controller reset pulse without write response");
  a_range_resp: assert property (range_apply_pulse |-> $rose(s_axi_bvalid))
    else $error("range pulse without write response");
  a_ref_legal: assert property (!(ref_index_bit1 && !ref_index_bit0))
    else $error("unassigned reference index driven");
  a_pulse_single: assert property (any_pulse |=> !any_pulse)
    else $error("strobe pulse longer than one cycle");
  c_sync: cover property (sync_update_pulse);
  c_clear: cover property (outputs_reset_pulse);
  c_range: cover property (range_apply_pulse);
endmodule // dsc_regs_asserts

bind dsc_regs dsc_regs_asserts u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid,
  .dac_out, .sync_mode, .cal_value, .cal_value_pulse, .cal_ctrl_reset_pulse, .outputs_reset_pulse,
  .sync_update_pulse, .range_apply_pulse, .ref_index_bit1, .ref_index_bit0);

// ==== bench/dsc_regs_bench.sv ====
// self-checking bench of the strobe and calibration register block
module dsc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic sync_mode, rb1, rb0;
  logic [7:0] awaddr, araddr, cal_result, cal_value;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [127:0] dac_out;
  logic [15:0] dac_range;
  logic [3:0] wstrb;
  wire [4:0] pulses;
  int errors, compares;

  dsc_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cal_result(cal_result),
    .dac_out(dac_out), .dac_range(dac_range), .sync_mode(sync_mode), .cal_value(cal_value),
    .cal_value_pulse(pulses[4]), .cal_ctrl_reset_pulse(pulses[3]), .outputs_reset_pulse(pulses[2]),
    .sync_update_pulse(pulses[1]), .range_apply_pulse(pulses[0]), .ref_index_bit1(rb1), .ref_index_bit0(rb0));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // pulses are sampled with bvalid, then must be gone one cycle later
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input logic [4:0] ep);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
    chk(pulses, ep);
    @(posedge aclk);
    chk(pulses, 5'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, 2'b00);
  endtask

  task automatic t_cal;
    cal_result <= 8'h5a;
    wr(8'h50, 32'h0000_0002, 2'b00, 5'h00);
    wr(8'h78, 32'h0000_abcd, 2'b00, 5'h10);
    chk(cal_value, 8'hcd);
    rd(8'h78, 32'h0000_005a);
    wr(8'h60, 32'h0000_0001, 2'b10, 5'h00);
  endtask

  task automatic t_direct;
    wr(8'h08, 32'h0000_1234, 2'b00, 5'h00);
    chk(dac_out[31:16], 16'h1234);
    wstrb <= 4'h1;
    wr(8'h08, 32'h0000_ab56, 2'b00, 5'h00);
    chk(dac_out[31:16], 16'h1256);
    wstrb <= 4'h3;
  endtask

  task automatic t_sync;
    wr(8'h48, 32'h0000_0001, 2'b00, 5'h00);
    chk(sync_mode, 1'b1);
    wr(8'h00, 32'h0000_5555, 2'b00, 5'h00);
    chk(dac_out[31:0], 32'h1256_0000);
    wr(8'h80, 32'h0000_0000, 2'b00, 5'h02);
    chk(dac_out[31:0], 32'h1256_5555);
    rd(8'h80, 32'h0000_0000);
  endtask

  task automatic t_clear;
    wr(8'h88, 32'hffff_ffff, 2'b00, 5'h04);
    chk(dac_out, 128'h0);
    wr(8'h90, 32'h0000_0000, 2'b00, 5'h08);
  endtask

  // range 2'b10 for channel 3; other ranges stay at reset
  task automatic t_range;
    wr(8'h50, 32'h0000_0013, 2'b00, 5'h00);
    chk(dac_range, 16'h0000);
    wr(8'h98, 32'h0000_0000, 2'b00, 5'h01);
    chk(dac_range, 16'h0080);
  endtask

  // upper bits set to show they are ignored
  task automatic t_ref;
    logic [1:0] c [3];
    c = '{2'b00, 2'b01, 2'b11};
    foreach (c[i]) begin
      wr(8'ha0, {30'h3fff_ffff, c[i]}, 2'b00, 5'h00);
      chk({rb1, rb0}, c[i]);
    end
    wr(8'ha0, 32'h0000_0002, 2'b00, 5'h00);
    chk({rb1, rb0}, 2'b11);
  endtask

  task automatic summarize;
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // the whole sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge aclk);
    errors++;
    summarize();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h3;
    cal_result = 8'h00;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_cal();
    t_direct();
    t_sync();
    t_clear();
    t_range();
    t_ref();
    summarize();
  end
endmodule // dsc_regs_bench
